// file: rtl/srzc_top.sv
// Speed reference filter, zero clamp position hold and quadrature pulse output
`timescale 1ns/10ps
// Operation
// - Lag filter smooths analog speed reference
// - Clamp request plus low reference locks servo
// - Clamp ignores reference, runs internal position loop
// - Hold captured position, return after displacement
// - Method A with mode bit 0 uses proportional input as request
// - Request released ends clamp, normal reference
// - Allocation mode 1 uses dedicated clamp input
// - Clamp only for methods 0,3,4,5,6,7,9,A
// - Dual methods clamp only in speed modes
// - Allocation 7 clamps without any input
// - Clamp level 0 to 10000, immediate
// - Clamp level limited to maximum speed
// - A and B phases ninety degrees apart
// - Output rate divided by resolution setting
// - Origin pulse C with complement
// - Origin pulse width equals phase A
module srzc_top
  import srzc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic signed [SRZC_REF_W-1:0] speed_ref_in,
  input wire logic proportional_control_input,
  input wire logic clamp_request_input,
  input wire logic alt_method_active,
  input wire logic scale_a,
  input wire logic scale_b,
  input wire logic scale_origin,
  output logic signed [SRZC_REF_W-1:0] speed_cmd,
  output logic speed_cmd_valid,
  input wire logic speed_cmd_ready,
  output logic clamp_active,
  output logic quad_out_a,
  output logic quad_out_a_n,
  output logic quad_out_b,
  output logic quad_out_b_n,
  output logic origin_out,
  output logic origin_out_n
);
  // ==========================================================
  // Settings registers
  logic [15:0] tc_r;
  logic [13:0] lvl_r;
  logic [15:0] cfg_r;
  logic [12:0] res_r;
  logic [15:0] maxspd_r;
  logic [15:0] kp_r;
  logic [3:0] cm_act_r;
  logic mode_act_r;
  logic [3:0] alloc_act_r;
  logic [12:0] res_act_r;
  logic started_r;
  logic [31:0] rdata_nxt;
  logic signed [SRZC_POS_W-1:0] pos_r;
  logic signed [SRZC_REF_W-1:0] filt_r;
  // Level writes saturate at the top of the clamp range; the whole word is
  // compared so a large write cannot wrap into a small level
  wire [13:0] lvl_wr = (reg_wdata > 32'(SRZC_CLAMP_LVL_MAX)) ? SRZC_CLAMP_LVL_MAX
    : reg_wdata[13:0];
  wire [12:0] res_wr = (reg_wdata[12:0] == 13'h0000) ? 13'h0001 : reg_wdata[12:0];
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      tc_r <= SRZC_TC_RST;
      lvl_r <= SRZC_CLAMP_LVL_RST;
      cfg_r <= {12'h000, SRZC_CM_RST};
      res_r <= SRZC_RES_RST;
      maxspd_r <= SRZC_MAXSPD_RST;
      kp_r <= SRZC_KP_RST;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        SRZC_A_TC: tc_r <= reg_wdata[15:0];
        SRZC_A_LVL: lvl_r <= lvl_wr;
        SRZC_A_CFG: cfg_r <= reg_wdata[15:0];
        SRZC_A_RES: res_r <= res_wr;
        SRZC_A_MAXSPD: maxspd_r <= reg_wdata[15:0];
        SRZC_A_KP: kp_r <= reg_wdata[15:0];
        default: ;
      endcase
    end
  end
  // Restart-latched copies; taken once after reset release and again on each write of 1 to STAT bit 0
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      started_r <= 1'b0;
      cm_act_r <= SRZC_CM_RST;
      mode_act_r <= 1'b0;
      alloc_act_r <= 4'h0;
      res_act_r <= SRZC_RES_RST;
    end
    else if (!started_r || (reg_wr && reg_addr == SRZC_A_STAT && reg_wdata[0]))
    begin
      started_r <= 1'b1;
      cm_act_r <= cfg_r[SRZC_CFG_CM_LSB +: 4];
      mode_act_r <= cfg_r[SRZC_CFG_MODE_BIT];
      alloc_act_r <= cfg_r[SRZC_CFG_ALLOC_LSB +: 4];
      res_act_r <= res_r;
    end
  end
  // Read mux; data stand one cycle after the strobe
  always_comb
  begin
    unique case (reg_addr)
      SRZC_A_TC: rdata_nxt = {16'h0000, tc_r};
      SRZC_A_LVL: rdata_nxt = {18'h00000, lvl_r};
      SRZC_A_CFG: rdata_nxt = {16'h0000, cfg_r};
      SRZC_A_RES: rdata_nxt = {19'h00000, res_r};
      SRZC_A_STAT: rdata_nxt = {15'h0000, filt_r, clamp_active};
      SRZC_A_POS: rdata_nxt = pos_r;
      SRZC_A_MAXSPD: rdata_nxt = {16'h0000, maxspd_r};
      SRZC_A_KP: rdata_nxt = {16'h0000, kp_r};
      default: rdata_nxt = 32'h00000000;
    endcase
  end
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      reg_rdata <= 32'h00000000;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
  end
  // ==========================================================
  // Pin synchronisers
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
    end
    else
    begin
      sync1_r <= {proportional_control_input, clamp_request_input, alt_method_active,
        scale_a, scale_b, scale_origin};
      sync2_r <= sync1_r;
    end
  end
  wire pcon_s = sync2_r[5];
  wire zreq_s = sync2_r[4];
  wire alt_s = sync2_r[3];
  wire sa_s = sync2_r[2];
  wire sb_s = sync2_r[1];
  wire sz_s = sync2_r[0];
  // ==========================================================
  // Control cycle tick and lag filter
  logic [15:0] tick_cnt_r;
  wire tick = (tick_cnt_r == 16'(SRZC_CTRL_CYC - 1));
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      tick_cnt_r <= 16'h0000;
    else
      tick_cnt_r <= tick ? 16'h0000 : tick_cnt_r + 16'h0001;
  end
  // y += (x - y) * T / (T + tau); T/tau steps are one per control cycle
  wire signed [SRZC_REF_W:0] f_err = 17'(speed_ref_in) - 17'(filt_r);
  wire [16:0] f_den = 17'(tc_r) + 17'(SRZC_CTRL_PERIOD_NS / SRZC_TC_STEP_NS);
  wire signed [SRZC_REF_W:0] f_step = 17'(f_err / $signed({1'b0, f_den}));
  // Small errors still converge so the output settles on the input
  wire signed [SRZC_REF_W:0] f_inc = (f_step != 17'sh0) ? f_step
    : (f_err > 0 ? 17'sh1 : (f_err < 0 ? -17'sh1 : 17'sh0));
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      filt_r <= '0;
    else if (tick)
      filt_r <= SRZC_REF_W'(17'(filt_r) + f_inc);
  end
  // ==========================================================
  // Zero clamp decision
  wire method_ok = (cm_act_r == SRZC_CM_SPD) || (cm_act_r == SRZC_CM_ISS)
    || (cm_act_r == SRZC_CM_ISS_SPD) || (cm_act_r == SRZC_CM_ISS_POS)
    || (cm_act_r == SRZC_CM_ISS_FRC) || (cm_act_r == SRZC_CM_POS_SPD)
    || (cm_act_r == SRZC_CM_FRC_SPD) || (cm_act_r == SRZC_CM_SPD_ZC);
  // Dual methods: alt_s high means the non-speed side is in control
  wire dual = (cm_act_r == SRZC_CM_ISS_POS) || (cm_act_r == SRZC_CM_ISS_FRC)
    || (cm_act_r == SRZC_CM_POS_SPD) || (cm_act_r == SRZC_CM_FRC_SPD);
  wire speed_side = !(dual && alt_s);
  wire req_sel = (alloc_act_r == SRZC_ALLOC_ALWAYS) ? 1'b1
    : mode_act_r ? zreq_s
    : (cm_act_r == SRZC_CM_SPD_ZC) ? pcon_s : 1'b0;
  wire [15:0] lvl_eff = (16'(lvl_r) > maxspd_r) ? maxspd_r : 16'(lvl_r);
  wire [15:0] ref_mag = filt_r[SRZC_REF_W-1] ? 16'(-filt_r) : 16'(filt_r);
  // Level compared live so changes act at once
  wire clamp_nxt = method_ok && speed_side && req_sel && (ref_mag < lvl_eff);
  logic clamp_r;
  logic signed [SRZC_POS_W-1:0] hold_r;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      clamp_r <= 1'b0;
      hold_r <= '0;
    end
    else
    begin
      clamp_r <= clamp_nxt;
      if (clamp_nxt && !clamp_r)
        hold_r <= pos_r;
    end
  end
  assign clamp_active = clamp_r;
  // ==========================================================
  // Position loop: command proportional to error, deadband of one count
  wire signed [SRZC_POS_W-1:0] perr = hold_r - pos_r;
  wire signed [47:0] pterm = 48'(perr) * 48'($signed({1'b0, kp_r})) >>> 4;
  wire signed [SRZC_REF_W-1:0] pcmd = (pterm > 48'sh7FFF) ? 16'sh7FFF
    : (pterm < -48'sh7FFF) ? -16'sh7FFF : pterm[15:0];
  wire hold_ok = (perr <= 1) && (perr >= -1);
  wire signed [SRZC_REF_W-1:0] cmd_sel = clamp_r ? (hold_ok ? '0 : pcmd)
    : filt_r;
  srzc_cmd_t cmd_in;
  srzc_cmd_t cmd_out;
  assign cmd_in = '{clamp: clamp_r, cmd: cmd_sel};
  srzc_buf2 #(.W($bits(srzc_cmd_t))) u_buf
  (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(tick),
    .in_ready(),
    .in_data(cmd_in),
    .out_valid(speed_cmd_valid),
    .out_ready(speed_cmd_ready),
    .out_data(cmd_out)
  );
  assign speed_cmd = cmd_out.cmd;
  // ==========================================================
  // Scale decoder: quadrature edges counted into position
  logic sa_d_r;
  logic sb_d_r;
  logic sz_d_r;
  wire sc_step = (sa_s ^ sa_d_r) || (sb_s ^ sb_d_r);
  wire sc_up = sa_d_r ^ sb_s;
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sa_d_r <= 1'b0;
      sb_d_r <= 1'b0;
      sz_d_r <= 1'b0;
      pos_r <= '0;
    end
    else
    begin
      sa_d_r <= sa_s;
      sb_d_r <= sb_s;
      sz_d_r <= sz_s;
      if (sc_step)
        pos_r <= sc_up ? pos_r + 1 : pos_r - 1;
    end
  end
  // ==========================================================
  // Output divider: one output edge per res_act_r input edges
  logic [12:0] div_cnt_r;
  logic [1:0] qstate_r;
  logic origin_r;
  logic [12:0] org_cnt_r;
  wire div_hit = sc_step && (sc_up ? (div_cnt_r + 13'h0001 >= res_act_r)
    : (div_cnt_r == 13'h0000));
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      div_cnt_r <= 13'h0000;
      qstate_r <= 2'b00;
    end
    else if (sc_step)
    begin
      if (sc_up)
        div_cnt_r <= div_hit ? 13'h0000 : div_cnt_r + 13'h0001;
      else
        div_cnt_r <= div_hit ? res_act_r - 13'h0001 : div_cnt_r - 13'h0001;
      if (div_hit)
        qstate_r <= sc_up ? qstate_r + 2'b01 : qstate_r - 2'b01;
    end
  end
  // Origin pulse lasts one output phase period of A high, counted in edges
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      origin_r <= 1'b0;
      org_cnt_r <= 13'h0000;
    end
    else if (sz_s && !sz_d_r)
    begin
      origin_r <= 1'b1;
      org_cnt_r <= 13'h0000;
    end
    else if (origin_r && div_hit)
    begin
      org_cnt_r <= org_cnt_r + 13'h0001;
      if (org_cnt_r == 13'h0001)
        origin_r <= 1'b0;
    end
  end
  // Gray sequence 00,01,11,10 puts B a quarter period behind A
  srzc_quad_t quad_nxt;
  srzc_quad_t quad_r;
  assign quad_nxt = '{a: qstate_r[1] ^ qstate_r[0], a_n: !(qstate_r[1] ^ qstate_r[0]),
    b: qstate_r[1], b_n: !qstate_r[1], c: origin_r, c_n: !origin_r};
  // Pins come from flops so the decode cannot glitch when both state bits move
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      quad_r <= '{a: 1'b0, a_n: 1'b1, b: 1'b0, b_n: 1'b1, c: 1'b0, c_n: 1'b1};
    else
      quad_r <= quad_nxt;
  end
  assign quad_out_a = quad_r.a;
  assign quad_out_a_n = quad_r.a_n;
  assign quad_out_b = quad_r.b;
  assign quad_out_b_n = quad_r.b_n;
  assign origin_out = quad_r.c;
  assign origin_out_n = quad_r.c_n;
endmodule

// file: rtl/srzc_pkg.sv
// Shared constants and carriers for the speed reference, zero clamp and pulse output block
package srzc_pkg;
  // Widths
  localparam int SRZC_REF_W = 16;
  localparam int SRZC_POS_W = 32;
  // Clock figures
  localparam int SRZC_CLK_MHZ = 100;
  localparam int SRZC_CLK_NS = 10;
  // Filter time constant step is 0.01 ms, written here in ns
  localparam int SRZC_TC_STEP_NS = 10000;
  // Control cycle of the filter and position loop, in ns
  localparam int SRZC_CTRL_PERIOD_NS = 10000;
  localparam int SRZC_CTRL_CYC = SRZC_CTRL_PERIOD_NS / SRZC_CLK_NS;
  // Settings reset values
  localparam logic [15:0] SRZC_TC_RST = 16'h0028;
  localparam logic [13:0] SRZC_CLAMP_LVL_RST = 14'h000A;
  localparam logic [13:0] SRZC_CLAMP_LVL_MAX = 14'h2710;
  localparam logic [12:0] SRZC_RES_RST = 13'h0014;
  localparam logic [3:0] SRZC_CM_RST = 4'h0;
  // Control method codes
  localparam logic [3:0] SRZC_CM_SPD = 4'h0;
  localparam logic [3:0] SRZC_CM_ISS = 4'h3;
  localparam logic [3:0] SRZC_CM_ISS_SPD = 4'h4;
  localparam logic [3:0] SRZC_CM_ISS_POS = 4'h5;
  localparam logic [3:0] SRZC_CM_ISS_FRC = 4'h6;
  localparam logic [3:0] SRZC_CM_POS_SPD = 4'h7;
  localparam logic [3:0] SRZC_CM_FRC_SPD = 4'h9;
  localparam logic [3:0] SRZC_CM_SPD_ZC = 4'hA;
  // Clamp input allocation code meaning always on
  localparam logic [3:0] SRZC_ALLOC_ALWAYS = 4'h7;
  // Register offsets
  localparam logic [3:0] SRZC_A_TC = 4'h0;
  localparam logic [3:0] SRZC_A_LVL = 4'h1;
  localparam logic [3:0] SRZC_A_CFG = 4'h2;
  localparam logic [3:0] SRZC_A_RES = 4'h3;
  localparam logic [3:0] SRZC_A_STAT = 4'h4;
  localparam logic [3:0] SRZC_A_POS = 4'h5;
  localparam logic [3:0] SRZC_A_MAXSPD = 4'h6;
  localparam logic [3:0] SRZC_A_KP = 4'h7;
  // CFG field positions
  localparam int SRZC_CFG_CM_LSB = 0;
  localparam int SRZC_CFG_MODE_BIT = 4;
  localparam int SRZC_CFG_ALLOC_LSB = 8;
  localparam logic [15:0] SRZC_KP_RST = 16'h0040;
  localparam logic [15:0] SRZC_MAXSPD_RST = 16'h1388;
  // Speed command sample passed to the loop
  typedef struct packed {
    logic clamp;
    logic signed [SRZC_REF_W-1:0] cmd;
  } srzc_cmd_t;
  // Quadrature output pins
  typedef struct packed {
    logic a;
    logic a_n;
    logic b;
    logic b_n;
    logic c;
    logic c_n;
  } srzc_quad_t;
endpackage

// file: rtl/srzc_buf2.sv
// Two-entry valid/ready buffer with registered output data
`timescale 1ns/10ps
module srzc_buf2
  import srzc_pkg::*;
#(
  parameter int W = 17
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] skid_r;
  logic skid_vld_r;
  logic out_vld_r;
  wire take_in = in_valid && in_ready;
  wire take_out = out_vld_r && out_ready;
  // Ready only while the skid slot is free, so a stall loses nothing
  assign in_ready = !skid_vld_r;
  assign out_valid = out_vld_r;
  // Output slot refills from skid first to keep order
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      out_vld_r <= 1'b0;
      skid_vld_r <= 1'b0;
      out_data <= '0;
      skid_r <= '0;
    end
    else if (!out_vld_r || take_out)
    begin
      out_vld_r <= skid_vld_r || take_in;
      out_data <= skid_vld_r ? skid_r : in_data;
      skid_vld_r <= 1'b0;
      if (skid_vld_r && take_in)
      begin
        skid_r <= in_data;
        skid_vld_r <= 1'b1;
      end
    end
    else if (take_in)
    begin
      skid_r <= in_data;
      skid_vld_r <= 1'b1;
    end
  end
endmodule

// file: tb/srzc_properties.sv
// Port assertions for the speed reference, zero clamp and pulse output block
`timescale 1ns/10ps
module srzc_properties
  import srzc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic scale_a,
  input wire logic scale_b,
  input wire logic scale_origin,
  input wire logic signed [SRZC_REF_W-1:0] speed_cmd,
  input wire logic speed_cmd_valid,
  input wire logic speed_cmd_ready,
  input wire logic clamp_active,
  input wire logic quad_out_a,
  input wire logic quad_out_a_n,
  input wire logic quad_out_b,
  input wire logic quad_out_b_n,
  input wire logic origin_out,
  input wire logic origin_out_n
);
  // ==========================================================
  // Assertions, one clock domain
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  a_pair_a: assert property (quad_out_a_n == !quad_out_a)
    else $error("phase A pair not complementary");
  a_pair_b: assert property (quad_out_b_n == !quad_out_b)
    else $error("phase B pair not complementary");
  a_pair_c: assert property (origin_out_n == !origin_out)
    else $error("origin pair not complementary");
  // A and B never move together, or the host would lose the count direction
  a_gray_step: assert property (!($changed(quad_out_a) && $changed(quad_out_b)))
    else $error("both phases moved in one cycle");
  a_quad_quiet: assert property (($stable(scale_a) && $stable(scale_b)) [*8]
    |-> $stable(quad_out_a) && $stable(quad_out_b))
    else $error("phase output moved without scale motion");
  a_origin_cause: assert property (!scale_origin [*8] |-> !$rose(origin_out))
    else $error("origin pulse without origin mark");
  a_stall_hold: assert property (speed_cmd_valid && !speed_cmd_ready
    |=> speed_cmd_valid && $stable(speed_cmd))
    else $error("stalled word dropped or changed");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (reg_rd && reg_addr[3] |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  c_clamp: cover property ($rose(clamp_active));
  c_stall: cover property (speed_cmd_valid && !speed_cmd_ready);
  c_origin: cover property ($rose(origin_out));
endmodule
bind srzc_top srzc_properties u_props (.core_clk(core_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scale_a(scale_a),
  .scale_b(scale_b), .scale_origin(scale_origin), .speed_cmd(speed_cmd),
  .speed_cmd_valid(speed_cmd_valid), .speed_cmd_ready(speed_cmd_ready),
  .clamp_active(clamp_active), .quad_out_a(quad_out_a), .quad_out_a_n(quad_out_a_n),
  .quad_out_b(quad_out_b), .quad_out_b_n(quad_out_b_n), .origin_out(origin_out),
  .origin_out_n(origin_out_n));

// file: tb/srzc_host_model.sv
// Host side model: moves the linear scale and counts quadrature output edges
`timescale 1ns/10ps
module srzc_host_model
  import srzc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] step_req,
  input wire logic go,
  input wire logic origin_req,
  input wire logic stall,
  input wire logic quad_out_a,
  input wire logic quad_out_b,
  output logic scale_a,
  output logic scale_b,
  output logic scale_origin,
  output logic speed_cmd_ready,
  output logic busy,
  output logic [15:0] edge_cnt
);
  logic [7:0] left_r;
  logic [1:0] div_r;
  logic [1:0] ph_r;
  logic qa_r;
  logic qb_r;
  // Scale lines follow a gray count, so only one line moves per step
  assign scale_a = ph_r[1];
  assign scale_b = ph_r[1] ^ ph_r[0];
  assign scale_origin = origin_req;
  assign speed_cmd_ready = !stall;
  assign busy = left_r != 8'h00;
  // One scale step every four clocks, slow enough for the input synchronisers
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      left_r <= 8'h00;
      div_r <= 2'h0;
      ph_r <= 2'h0;
      edge_cnt <= 16'h0000;
      qa_r <= 1'h0;
      qb_r <= 1'h0;
    end
    else
    begin
      if (go)
        left_r <= step_req;
      else if (busy && div_r == 2'h3)
        left_r <= left_r - 8'h01;
      if (busy)
        div_r <= div_r + 2'h1;
      if (busy && div_r == 2'h3)
        ph_r <= ph_r + 2'h1;
      if (quad_out_a != qa_r || quad_out_b != qb_r)
        edge_cnt <= edge_cnt + 16'h0001;
      qa_r <= quad_out_a;
      qb_r <= quad_out_b;
    end
  end
endmodule

// file: tb/srzc_top_tb_top.sv
// Self-checking bench for the speed reference, zero clamp and pulse output block
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
  begin \
    tests_run++; \
    if ((got) !== (ex)) \
    begin \
      n_errors++; \
      $display("BAD %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module srzc_top_tb_top
  import srzc_pkg::*;
;
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'h0;
  logic reg_rd = 1'h0;
  logic [31:0] reg_rdata;
  logic signed [SRZC_REF_W-1:0] speed_ref_in = 16'sh0;
  logic proportional_control_input = 1'h0;
  logic clamp_request_input = 1'h0;
  logic alt_method_active = 1'h0;
  logic scale_a, scale_b, scale_origin, busy;
  logic signed [SRZC_REF_W-1:0] speed_cmd;
  logic speed_cmd_valid, speed_cmd_ready, clamp_active;
  logic quad_out_a, quad_out_a_n, quad_out_b, quad_out_b_n, origin_out, origin_out_n;
  logic [7:0] step_req = 8'h00;
  logic go = 1'h0;
  logic origin_req = 1'h0;
  logic stall = 1'h0;
  logic [15:0] edge_cnt;
  int n_errors = 0;
  int tests_run = 0;
  always #5 core_clk = ~core_clk;
  srzc_top uut (.*);
  srzc_host_model host (.*);
  // ==========================================================
  // Register port tasks
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] ex);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    @(negedge core_clk);
    `CHK("reg", ex, reg_rdata)
  endtask
  // Move the scale and wait, bounded, until the model is idle again
  task automatic move(input logic [7:0] n);
    int k;
    @(posedge core_clk);
    step_req <= n;
    go <= 1'h1;
    @(posedge core_clk);
    go <= 1'h0;
    @(negedge core_clk);
    for (k = 0; k < 1200 && busy; k++) @(negedge core_clk);
    // Let the last step pass the synchronisers, decoder and output flops
    repeat (20) @(negedge core_clk);
  endtask
  // Restart with a method set, apply pins and reference, check clamp and next word
  task automatic ccase(input logic [31:0] cfg, input logic [2:0] pins,
    input logic signed [15:0] r, input logic ex);
    int k;
    wr(SRZC_A_CFG, cfg);
    wr(SRZC_A_STAT, 32'h1);
    {proportional_control_input, clamp_request_input, alt_method_active} <= pins;
    speed_ref_in <= r;
    repeat (2100) @(posedge core_clk);
    @(negedge core_clk);
    `CHK("clamp", ex, clamp_active)
    rchk(SRZC_A_STAT, {15'h0, r, ex});
    for (k = 0; k < 1200 && !(speed_cmd_valid && speed_cmd_ready); k++) @(negedge core_clk);
    `CHK("speed cmd", ex ? 16'sh0 : r, speed_cmd)
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    int m;
    int k;
    logic [15:0] e0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'h1;
    rchk(SRZC_A_TC, 32'h28);
    rchk(SRZC_A_LVL, 32'hA);
    rchk(SRZC_A_RES, 32'h14);
    rchk(SRZC_A_MAXSPD, 32'h1388);
    rchk(4'hC, 32'h0);
    wr(SRZC_A_LVL, 32'h4E20);
    rchk(SRZC_A_LVL, 32'h2710);
    wr(SRZC_A_LVL, 32'hA);
    // Zero time constant lets the filtered reference follow within one tick
    wr(SRZC_A_TC, 32'h0);
    ccase(32'h10A, 3'h4, 16'sh0, 1'h1);
    ccase(32'h10A, 3'h0, 16'sh0, 1'h0);
    ccase(32'h10A, 3'h4, 16'sh9, 1'h1);
    ccase(32'h10A, 3'h4, 16'shA, 1'h0);
    ccase(32'h11A, 3'h4, 16'sh0, 1'h0);
    ccase(32'h11A, 3'h2, 16'sh0, 1'h1);
    ccase(32'h705, 3'h1, 16'sh0, 1'h0);
    for (m = 0; m < 16; m++)
      ccase(32'h700 | m, 3'h0, 16'sh0, m inside {0, 3, 4, 5, 6, 7, 9, 10});
    wr(SRZC_A_MAXSPD, 32'h5);
    ccase(32'h700, 3'h0, 16'sh7, 1'h0);
    wr(SRZC_A_MAXSPD, 32'h1388);
    // Resolution is taken at restart only
    wr(SRZC_A_RES, 32'h4);
    wr(SRZC_A_STAT, 32'h1);
    e0 = edge_cnt;
    move(8'h10);
    `CHK("quad edges", 16'h4, edge_cnt - e0)
    rchk(SRZC_A_POS, 32'h10);
    // Clamp is still on, so the loop must push back against the displacement
    for (k = 0; k < 1200 && !(speed_cmd_valid && speed_cmd_ready); k++) @(negedge core_clk);
    `CHK("hold drive back", 1'h1, clamp_active && speed_cmd < 0)
    @(posedge core_clk);
    origin_req <= 1'h1;
    for (k = 0; k < 50 && !origin_out; k++) @(negedge core_clk);
    `CHK("origin", 1'h1, origin_out)
    @(posedge core_clk);
    origin_req <= 1'h0;
    move(8'h4);
    `CHK("origin held", 1'h1, origin_out)
    move(8'h4);
    `CHK("origin width", 1'h0, origin_out)
    // Start the stall just after a tick so no new tick lands in the drain window
    for (k = 0; k < 1200 && !speed_cmd_valid; k++) @(negedge core_clk);
    // Receiver stalls across several ticks; two words must survive
    @(posedge core_clk);
    stall <= 1'h1;
    repeat (3000) @(posedge core_clk);
    @(negedge core_clk);
    `CHK("stall valid", 1'h1, speed_cmd_valid)
    @(posedge core_clk);
    stall <= 1'h0;
    m = 0;
    for (k = 0; k < 10; k++)
    begin
      @(negedge core_clk);
      if (speed_cmd_valid === 1'h1)
        m++;
    end
    `CHK("drained words", 2, m)
    `CHK("empty", 1'h0, speed_cmd_valid)
    finish_test();
  end
  // Watchdog well past the expected length of the sequence
  initial
  begin
    repeat (99000) @(posedge core_clk);
    n_errors++;
    finish_test();
  end
endmodule
